// ==== hw/mpp_map.vh ====
// offsets, field positions, reset values and codes for the mode parameter parser
`ifndef MPP_MAP_VH
`define MPP_MAP_VH
// register byte offsets
`define MPP_CTRL_OFS     8'h00
`define MPP_STAT_OFS     8'h04
`define MPP_OPER_OFS     8'h08
`define MPP_ERRP_OFS     8'h0c
`define MPP_BCNT_OFS     8'h10
`define MPP_BLEN_OFS     8'h14
`define MPP_SENSE_OFS    8'h18
// control fields
`define MPP_CTRL_START   0
`define MPP_CTRL_SAVE    1
`define MPP_CTRL_LEN_LO  8
// list layout
`define MPP_HDR_BYTES    3'd4
`define MPP_DESC_BYTES   3'd7
`define MPP_MEDIUM_TYPE  8'h00
`define MPP_PAGE_MASK    8'h3f
// page codes
`define MPP_PG_OPER      6'h00
`define MPP_PG_ERR       6'h01
// error recovery page bits (byte 2)
`define MPP_B_SEND       5
`define MPP_B_EARLY      3
`define MPP_B_POST       2
`define MPP_B_STOP       1
`define MPP_B_NOCORR     0
// operating page bits (byte 2)
`define MPP_B_USAGE      7
`define MPP_B_INHIBIT    6
`define MPP_B_RSTAT      5
`define MPP_B_RESETST    4
// reset values
`define MPP_RETRY_RST    8'h08
`define MPP_FLAGS_RST    8'h00
`define MPP_DTQ_RST      8'h00
`endif

// ==== hw/mpp_parser.v ====
// mode parameter list parser with flag application, error policy and axi4-lite registers
`timescale 1ns/1ps
`include "mpp_map.vh"
// Function
// - header, descriptors, pages; zero length moves nothing
// - medium type zero; descriptor length eight per
// - descriptor: density, 24-bit count, reserved, length
// - zero count means max; zero length keeps
// - page code low six bits, length byte
// - decode page codes; ignore reserved ranges
// - format and geometry pages never altered here
// - one parameter set for whole drive
// - operating page flags and device qualifier
// - usage overflow raises error on next command
// - recovery inhibit reports every error unrecovered
// - recovered status report, void while inhibited
// - reset status report enabled by zero
// - error page flags and retry count layout
// - send failing block data when flag set
// - sense address is erring block itself
// - early correction before retries; else retries first
// - early correction with no correction is illegal
// - post error: check condition, last/first address
// - no post: only errors beyond limits posted, unless the recovered status report flag is set
// - stop on error with post stops immediately
// - stop without post is illegal request
// - no stop: post recovered after transfer ends
// - no correction disables correction only
// - retry count default eight
// - save bit saves savable pages after update
module mpp_parser #(
    parameter ADDR_W = 8
) (
    input  wire              clk,
    input  wire              reset,
    // axi4-lite slave
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // parameter byte stream from the data-out phase
    input  wire              prm_valid,
    input  wire [7:0]        prm_data,
    output wire              prm_ready,
    // media error events from the read channel
    input  wire              err_valid,
    input  wire              err_unrecov,
    input  wire [23:0]       err_lba,
    input  wire              xfer_end,
    input  wire              usage_ovf,
    input  wire              cmd_start,
    // policy outputs
    output wire              recovery_enable,
    output wire              correct_first,
    output wire              correct_enable,
    output wire [7:0]        retry_count,
    output wire              send_failing_block,
    output wire              report_reset_status,
    output reg               check_cond,
    output reg               sense_recovered,
    output reg  [23:0]       sense_lba,
    output reg               xfer_stop,
    output reg               usage_error,
    output reg               save_pulse,
    output reg               illegal_request
);

// ---------------------------------------------------------------
// parser states
// ---------------------------------------------------------------
localparam [2:0] ST_IDLE  = 3'd0;
localparam [2:0] ST_HDR   = 3'd1;
localparam [2:0] ST_DESC  = 3'd2;
localparam [2:0] ST_PCODE = 3'd3;
localparam [2:0] ST_PLEN  = 3'd4;
localparam [2:0] ST_BODY  = 3'd5;
localparam [2:0] ST_APPLY = 3'd6;

reg  [2:0]  state_q;
reg  [7:0]  remain_q;      // list bytes still to come
reg  [2:0]  idx_q;         // byte index inside header or descriptor
reg  [7:0]  dlen_q;        // descriptor bytes still to come
reg  [5:0]  pcode_q;
reg  [7:0]  plen_q;
reg  [7:0]  pcnt_q;
reg  [7:0]  pb2_q;         // staged page byte 2
reg  [7:0]  pb3_q;         // staged page byte 3
reg  [23:0] dcnt_tmp_q;
reg  [23:0] dlen_tmp_q;
reg         save_q;
reg         done_q;
// one drive-wide parameter set, never per initiator
reg  [7:0]  oper_q;
reg  [7:0]  dtq_q;
reg  [7:0]  errf_q;
reg  [7:0]  retry_q;
reg  [23:0] bcnt_q;
reg  [23:0] blen_q;
reg         bcnt_max_q;
reg         blen_keep_q;
reg         rec_pend_q;
reg         unrec_seen_q;

wire byte_ok = prm_valid && prm_ready;
wire last_b  = (remain_q == 8'h01);

// byte stream stalls while idle or applying a page
assign prm_ready = (state_q != ST_IDLE) && (state_q != ST_APPLY);

// ---------------------------------------------------------------
// register bus
// ---------------------------------------------------------------
reg              aw_got_q;
reg              w_got_q;
reg [ADDR_W-1:0] awaddr_q;
reg [31:0]       wdata_q;
reg              wstrb0_q;

assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

wire wr_fire  = aw_got_q && w_got_q && !s_axi_bvalid;
wire ctrl_hit = (awaddr_q[7:0] == `MPP_CTRL_OFS);
wire start    = wr_fire && ctrl_hit && wstrb0_q && wdata_q[`MPP_CTRL_START] && (state_q == ST_IDLE);

// word that a read at the given offset returns, and whether it is mapped
function [32:0] rd_word;
    input [7:0] a;
    begin
        if (a == `MPP_CTRL_OFS) begin
            rd_word = {1'b1, 22'h0, save_q, 1'b0, remain_q};
        end else if (a == `MPP_STAT_OFS) begin
            rd_word = {1'b1, 24'h0, blen_keep_q, bcnt_max_q, rec_pend_q, usage_error,
                       illegal_request, done_q, state_q != ST_IDLE, 1'b0};
        end else if (a == `MPP_OPER_OFS) begin
            rd_word = {1'b1, 16'h0, dtq_q, oper_q};
        end else if (a == `MPP_ERRP_OFS) begin
            rd_word = {1'b1, 16'h0, retry_q, errf_q};
        end else if (a == `MPP_BCNT_OFS) begin
            rd_word = {1'b1, 8'h0, bcnt_q};
        end else if (a == `MPP_BLEN_OFS) begin
            rd_word = {1'b1, 8'h0, blen_q};
        end else if (a == `MPP_SENSE_OFS) begin
            rd_word = {1'b1, 8'h0, sense_lba};
        end else begin
            rd_word = 33'h0;
        end
    end
endfunction

wire [32:0] rd_sel = rd_word(s_axi_araddr[7:0]);

// write channel: address and data taken in either order
always @(posedge clk) begin
    if (reset) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        awaddr_q     <= {ADDR_W{1'b0}};
        wdata_q      <= 32'h0;
        wstrb0_q     <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= 2'b00;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_q  <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= ctrl_hit ? 2'b00 : 2'b10; // only control is writable
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// read channel: answer one cycle after the address is taken
always @(posedge clk) begin
    if (reset) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata  <= 32'h0;
        s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_sel[31:0];
        s_axi_rresp  <= rd_sel[32] ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

// ---------------------------------------------------------------
// list parser
// ---------------------------------------------------------------
wire [7:0] err_new  = pb2_q;
// reject combinations before anything of the page is applied
wire bad_combo = (err_new[`MPP_B_EARLY] && err_new[`MPP_B_NOCORR]) ||
                 (err_new[`MPP_B_STOP] && !err_new[`MPP_B_POST]);
wire err_page  = (pcode_q == `MPP_PG_ERR);

always @(posedge clk) begin
    if (reset) begin
        state_q         <= ST_IDLE;
        remain_q        <= 8'h00;
        idx_q           <= 3'd0;
        dlen_q          <= 8'h00;
        pcode_q         <= 6'h00;
        plen_q          <= 8'h00;
        pcnt_q          <= 8'h00;
        pb2_q           <= 8'h00;
        pb3_q           <= 8'h00;
        dcnt_tmp_q      <= 24'h0;
        dlen_tmp_q      <= 24'h0;
        save_q          <= 1'b0;
        done_q          <= 1'b0;
        save_pulse      <= 1'b0;
        illegal_request <= 1'b0;
        oper_q          <= `MPP_FLAGS_RST;
        dtq_q           <= `MPP_DTQ_RST;
        errf_q          <= `MPP_FLAGS_RST;
        retry_q         <= `MPP_RETRY_RST;
        bcnt_q          <= 24'h0;
        blen_q          <= 24'h0;
        bcnt_max_q      <= 1'b1;
        blen_keep_q     <= 1'b1;
    end else begin
        save_pulse <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    remain_q        <= wdata_q[`MPP_CTRL_LEN_LO+7:`MPP_CTRL_LEN_LO];
                    save_q          <= wdata_q[`MPP_CTRL_SAVE];
                    illegal_request <= 1'b0;
                    done_q          <= 1'b0;
                    idx_q           <= 3'd0;
                    if (wdata_q[`MPP_CTRL_LEN_LO+7:`MPP_CTRL_LEN_LO] == 8'h00) begin
                        done_q <= 1'b1;
                    end else begin
                        state_q <= ST_HDR;
                    end
                end
            end
            ST_HDR: begin
                if (byte_ok) begin
                    idx_q <= idx_q + 3'd1;
                    if (idx_q == 3'd1 && prm_data != `MPP_MEDIUM_TYPE) begin
                        illegal_request <= 1'b1;
                    end
                    if (idx_q == 3'd3) begin
                        dlen_q <= prm_data;
                        idx_q  <= 3'd0;
                        if (prm_data[2:0] != 3'd0) begin
                            illegal_request <= 1'b1;
                        end
                        state_q <= (prm_data != 8'h00) ? ST_DESC : ST_PCODE;
                    end
                end
            end
            ST_DESC: begin
                if (byte_ok) begin
                    idx_q  <= idx_q + 3'd1;
                    dlen_q <= dlen_q - 8'h01;
                    // bytes 1-3 count, 4 reserved, 5-7 length, msb first
                    if (idx_q >= 3'd1 && idx_q <= 3'd3) begin
                        dcnt_tmp_q <= {dcnt_tmp_q[15:0], prm_data};
                    end
                    if (idx_q >= 3'd5) begin
                        dlen_tmp_q <= {dlen_tmp_q[15:0], prm_data};
                    end
                    if (idx_q == `MPP_DESC_BYTES) begin
                        bcnt_q      <= dcnt_tmp_q;
                        bcnt_max_q  <= (dcnt_tmp_q == 24'h0);
                        blen_keep_q <= ({dlen_tmp_q[15:0], prm_data} == 24'h0);
                        if ({dlen_tmp_q[15:0], prm_data} != 24'h0) begin
                            blen_q <= {dlen_tmp_q[15:0], prm_data};
                        end
                    end
                    if (dlen_q == 8'h01) begin
                        state_q <= ST_PCODE;
                    end
                end
            end
            ST_PCODE: begin
                if (byte_ok) begin
                    pcode_q <= prm_data[5:0];
                    state_q <= ST_PLEN;
                end
            end
            ST_PLEN: begin
                if (byte_ok) begin
                    plen_q  <= prm_data;
                    pcnt_q  <= 8'h00;
                    pb2_q   <= 8'h00;
                    pb3_q   <= 8'h00;
                    state_q <= (prm_data == 8'h00) ? ST_PCODE : ST_BODY;
                end
            end
            ST_BODY: begin
                if (byte_ok) begin
                    // unknown codes are stepped over by their own length
                    pcnt_q <= pcnt_q + 8'h01;
                    if (pcnt_q == 8'h00) begin
                        pb2_q <= prm_data;
                    end
                    if (pcnt_q == 8'h01) begin
                        pb3_q <= prm_data;
                    end
                    if (pcnt_q + 8'h01 == plen_q) begin
                        state_q <= ST_APPLY;
                    end
                end
            end
            ST_APPLY: begin
                // only operating and error pages change state; dma, format,
                // geometry and identification pages leave it alone
                if (pcode_q == `MPP_PG_OPER) begin
                    oper_q <= {pb2_q[7:4], 4'h0};
                    if (plen_q >= 8'h02) begin
                        dtq_q <= pb3_q;
                    end
                end else if (err_page && bad_combo) begin
                    illegal_request <= 1'b1;
                end else if (err_page) begin
                    errf_q <= pb2_q & 8'h2f;
                    if (plen_q >= 8'h02) begin
                        retry_q <= pb3_q;
                    end
                end
                state_q <= (remain_q == 8'h00) ? ST_IDLE : ST_PCODE;
                if (remain_q == 8'h00) begin
                    done_q     <= 1'b1;
                    save_pulse <= save_q && !illegal_request && !(err_page && bad_combo);
                end
            end
            default: begin
                state_q <= ST_IDLE;
            end
        endcase
        // list length bounds every byte state; a page cut short is dropped
        if (byte_ok) begin
            remain_q <= remain_q - 8'h01;
            if (last_b && !(state_q == ST_BODY && pcnt_q + 8'h01 == plen_q)) begin
                state_q    <= ST_IDLE;
                done_q     <= 1'b1;
                save_pulse <= save_q && !illegal_request;
            end
        end
    end
end

// ---------------------------------------------------------------
// error policy decode
// ---------------------------------------------------------------
wire inhibit_w = oper_q[`MPP_B_INHIBIT];
wire post_w    = errf_q[`MPP_B_POST];
wire stop_w    = errf_q[`MPP_B_STOP];

assign recovery_enable     = !inhibit_w;
assign correct_enable      = !inhibit_w && !errf_q[`MPP_B_NOCORR];
assign correct_first       = correct_enable && errf_q[`MPP_B_EARLY];
assign retry_count         = retry_q;
assign send_failing_block  = errf_q[`MPP_B_SEND];
assign report_reset_status = !oper_q[`MPP_B_RESETST];

// recovered errors count as reportable only when posting or the recovered status report is asked and
// recovery is allowed at all; an inhibited drive treats every error as hard
wire rec_ev   = err_valid && !err_unrecov && !inhibit_w;
wire hard_ev  = err_valid && (err_unrecov || inhibit_w);
wire rec_post = post_w || oper_q[`MPP_B_RSTAT];

always @(posedge clk) begin
    if (reset) begin
        check_cond      <= 1'b0;
        sense_recovered <= 1'b0;
        sense_lba       <= 24'h0;
        xfer_stop       <= 1'b0;
        rec_pend_q      <= 1'b0;
        unrec_seen_q    <= 1'b0;
        usage_error     <= 1'b0;
    end else begin
        check_cond <= 1'b0;
        xfer_stop  <= 1'b0;
        // overflow wins over the clear at the next command's start
        if (usage_ovf && oper_q[`MPP_B_USAGE]) begin
            usage_error <= 1'b1;
        end else if (cmd_start) begin
            usage_error <= 1'b0;
        end
        if (cmd_start) begin
            rec_pend_q   <= 1'b0;
            unrec_seen_q <= 1'b0;
        end
        if (hard_ev && !unrec_seen_q) begin
            // first hard error always posts and ends the transfer
            sense_lba       <= err_lba;
            sense_recovered <= 1'b0;
            check_cond      <= 1'b1;
            xfer_stop       <= 1'b1;
            unrec_seen_q    <= 1'b1;
            rec_pend_q      <= 1'b0;
        end else if (rec_ev && rec_post && !unrec_seen_q) begin
            sense_lba       <= err_lba;
            sense_recovered <= 1'b1;
            if (stop_w) begin
                check_cond   <= 1'b1;
                xfer_stop    <= 1'b1;
                unrec_seen_q <= 1'b1;
            end else begin
                rec_pend_q <= 1'b1;
            end
        end else if (xfer_end && rec_pend_q) begin
            check_cond <= 1'b1;
            rec_pend_q <= 1'b0;
        end
    end
end

endmodule // mpp_parser

// ==== tb/mpp_properties.sv ====
// concurrent checks on the ports of the mode parameter parser
`timescale 1ns/1ps
// ----------------------------------------
// checker
// ----------------------------------------
module mpp_properties (
    input logic        clk, reset, cmd_start, err_valid, err_unrecov, usage_ovf, prm_ready,
    input logic        s_axi_bvalid, s_axi_bready, save_pulse, illegal_request, check_cond, xfer_stop,
    input logic        usage_error, recovery_enable, correct_enable, correct_first, report_reset_status,
    input logic        send_failing_block,
    input logic [7:0]  retry_count,
    input logic [23:0] err_lba, sense_lba
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // defaults must show on the first edges after any reset
    a_retry_default: assert property ($past(reset) |-> retry_count == 8'h08)
        else $error("retry count not at default after reset");
    a_flag_defaults: assert property ($past(reset) |-> recovery_enable && report_reset_status
        && !send_failing_block && correct_enable && !correct_first) else $error("policy defaults wrong");
    a_parse_idle: assert property ($past(reset) |-> !prm_ready && !s_axi_bvalid)
        else $error("parser not idle after reset");
    a_first_needs: assert property (correct_first |-> correct_enable)
        else $error("early correction without correction");
    a_inhibit_nocorr: assert property (!recovery_enable |-> !correct_enable)
        else $error("correction while recovery inhibited");
    a_stop_posts: assert property (xfer_stop |-> check_cond)
        else $error("stop without check condition");
    a_hard_error: assert property (cmd_start ##1 (err_valid && err_unrecov) |=> check_cond && xfer_stop
        && sense_lba == $past(err_lba)) else $error("hard error not posted on its block");
    a_usage_clear: assert property (cmd_start && !usage_ovf |=> !usage_error)
        else $error("usage error kept over new command");
    a_save_legal: assert property (save_pulse |-> !illegal_request)
        else $error("save after rejected list");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
endmodule // mpp_properties

bind mpp_parser mpp_properties mpp_properties_inst (.*);

// ==== tb/mpp_initiator.sv ====
// initiator model feeding parameter list bytes into the parser
`timescale 1ns/1ps
// ----------------------------------------
// byte source
// ----------------------------------------
module mpp_initiator (
    input  logic       clk, reset, prm_ready, slow,
    output logic       prm_valid = 1'b0,
    output logic [7:0] prm_data = 8'h00
);
    logic [7:0] q[$];
    task push(input logic [7:0] b);
        q.push_back(b);
    endtask
    // bytes go out in list order and are held until taken; idle data toggles so no stale byte looks valid
    always @(posedge clk) begin
        if (reset) begin
            prm_valid <= 1'b0;
        end else if (!prm_valid || prm_ready) begin
            if (prm_valid) void'(q.pop_front());
            prm_valid <= q.size() > 0 && !slow;
            prm_data <= (q.size() > 0 && !slow) ? q[0] : ~prm_data;
        end
    end
endmodule // mpp_initiator

// ==== tb/mpp_parser_tb.sv ====
// self-checking bench for the mode parameter parser
`timescale 1ns/1ps
// ----------------------------------------
// bench
// ----------------------------------------
module mpp_parser_tb;
    logic        clk = 0, reset = 1, slow = 0, saw_save = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, prm_data, retry_count, f8, o8, rt, q8;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, prm_valid, prm_ready;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        err_valid = 0, err_unrecov = 0, xfer_end = 0, usage_ovf = 0, cmd_start = 0;
    logic [23:0] err_lba = 0, sense_lba, cnt;
    logic        recovery_enable, correct_first, correct_enable, send_failing_block, report_reset_status;
    logic        check_cond, sense_recovered, xfer_stop, usage_error, save_pulse, illegal_request;
    int          fails = 0, n_tests = 0, cyc = 0, i;
    integer      seed = 32'h64704add;
    logic [7:0]  lst[$];

    mpp_parser #(.ADDR_W(8)) mpp_parser_inst (.*);
    mpp_initiator mpp_initiator_inst (.*);

    always #4 clk = ~clk;
    // cycle ceiling, save monitor and random stalls of the initiator
    always @(posedge clk) begin
        cyc <= cyc + 1;
        slow <= ($random(seed) & 3) == 0;
        if (save_pulse === 1'b1) saw_save <= 1'b1;
        if (cyc > 60000) begin
            fails++;
            wrap_up;
        end
    end

    task chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("checks=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // handshakes are judged at the falling edge, where nothing moves; each call first lets an edge
    // pass so that a ready released by the previous call is never raised again in the same step
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin
            @(negedge clk); ta = s_axi_awvalid & s_axi_awready; tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid; r = s_axi_bresp;
            @(posedge clk); if (ta) s_axi_awvalid <= 0; if (tw) s_axi_wvalid <= 0; if (tb) s_axi_bready <= 0;
        end while (!tb);
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(negedge clk); ta = s_axi_arvalid & s_axi_arready; tr = s_axi_rvalid;
            d = s_axi_rdata; r = s_axi_rresp;
            @(posedge clk); if (ta) s_axi_arvalid <= 0; if (tr) s_axi_rready <= 0;
        end while (!tr);
    endtask
    // hand the list to the initiator, start the parse and wait until it is finished
    task run(input logic save);
        foreach (lst[k]) mpp_initiator_inst.push(lst[k]);
        axw(8'h00, {16'h0, 8'(lst.size()), 6'h0, save, 1'b1}, rs);
        do axr(8'h04, rd, rs); while (!(rd[1] === 1'b0 && rd[2] === 1'b1));
        lst.delete();
    endtask
    // reserved bits dropped, illegal pairs avoided
    function automatic logic [7:0] legal(input logic [7:0] f);
        legal = f & 8'h2f;
        if (legal[3]) legal[0] = 1'b0;
        if (legal[1]) legal[2] = 1'b1;
    endfunction

    initial begin
        repeat (5) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        axr(8'h0c, rd, rs); chk(rd & 32'hffff, 32'h0800);
        axr(8'h08, rd, rs); chk(rd & 32'hffff, 32'h0);
        axr(8'h04, rd, rs); chk(rd[7:6], 2'b11);
        axr(8'h1c, rd, rs); chk({rs, rd[29:0]}, 32'h80000000);
        axw(8'h08, 32'hff, rs); chk(rs, 2'b10);
        // random legal lists: descriptor, an ignored page, then both applied pages
        for (i = 0; i < 6; i++) begin
            f8 = legal($random(seed)); rt = $random(seed); o8 = $random(seed) & 8'hf0; q8 = $random(seed);
            cnt = (i == 0) ? 24'h0 : ($random(seed) | 1);
            lst = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, cnt[23:16], cnt[15:8], cnt[7:0], 8'h00, 8'h00,
                    (i == 0) ? 8'h00 : 8'h02, 8'h00, 8'h25, 8'h02, 8'haa, 8'h55, 8'h01, 8'h06, f8 | 8'hd0, rt,
                    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, o8, q8};
            run(i[0]);
            axr(8'h0c, rd, rs); chk(rd & 32'hffff, {rt, f8});
            axr(8'h08, rd, rs); chk(rd & 32'hffff, {q8, o8});
            axr(8'h04, rd, rs); chk({rd[7:6], rd[3]}, {i == 0, i == 0, 1'b0});
            if (i > 0) begin
                axr(8'h10, rd, rs); chk(rd, cnt);
                axr(8'h14, rd, rs); chk(rd, 32'h200);
            end
            chk({recovery_enable, correct_enable, correct_first, send_failing_block, report_reset_status,
                 retry_count}, {!o8[6], !o8[6] & !f8[0], !o8[6] & !f8[0] & f8[3], f8[5], !o8[4], rt});
        end
        chk(saw_save, 1'b1);
        // rejected lists leave the stored flags alone
        for (i = 0; i < 3; i++) begin
            if (i == 2) lst = '{8'h00, 8'h05, 8'h00, 8'h00};
            else lst = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, (i == 0) ? 8'h09 : 8'h02, 8'h33};
            run(1'b1);
            axr(8'h04, rd, rs); chk(rd[3], 1'b1);
            axr(8'h0c, rd, rs); chk(rd & 32'hffff, {rt, f8});
        end
        // post and stop set: each error is posted at once on its own block
        lst = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h26, 8'h08};
        run(1'b0);
        for (i = 0; i < 2; i++) begin
            @(posedge clk); cmd_start <= 1;
            @(posedge clk); cmd_start <= 0; err_valid <= 1; err_unrecov <= i[0]; err_lba <= $random(seed);
            @(posedge clk); err_valid <= 0;
            @(negedge clk); chk({check_cond, xfer_stop, sense_lba}, {2'b11, err_lba});
        end
        // post only with usage flag: recovered errors wait for the transfer end, last block reported
        lst = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h80, 8'h00, 8'h01, 8'h02, 8'h04, 8'h08};
        run(1'b0);
        @(posedge clk); cmd_start <= 1;
        for (i = 0; i < 2; i++) begin
            @(posedge clk); cmd_start <= 0; err_valid <= 1; err_unrecov <= 0; err_lba <= $random(seed);
            @(negedge clk); chk(check_cond, 1'b0);
        end
        @(posedge clk); err_valid <= 0;
        @(negedge clk); chk(check_cond, 1'b0);
        @(posedge clk); usage_ovf <= 1; xfer_end <= 1;
        @(posedge clk); usage_ovf <= 0; xfer_end <= 0; cmd_start <= 1;
        @(negedge clk); chk({check_cond, sense_recovered, sense_lba, usage_error}, {2'b11, err_lba, 1'b1});
        @(posedge clk); cmd_start <= 0;
        @(negedge clk); chk(usage_error, 1'b0);
        wrap_up;
    end
endmodule // mpp_parser_tb
